/* hdl/pwr_ctrl_core.sv */
// Regulator control core: registers, supervisors and serial bridge.
`timescale 1ns/1ns
module pwr_ctrl_core
    import pwr_ctrl_pkg::*;
#(
    parameter int MS_CYCLES = MS_CYCLES_DEF, // Reference cycles per ms.
    parameter logic [4:0] CODE_A_LOW = CODE_A_LOW_DEF, // Select low code.
    parameter logic [4:0] CODE_A_HIGH = CODE_A_HIGH_DEF // Select high code.
)(
    input wire logic clk_sys, // System clock, 100 MHz.
    input wire logic resetn, // Asynchronous reset, active low.
    input wire logic scl_clk, // Serial bus clock.
    input wire logic sda_in, // Serial data line level.
    output wire logic sda_o, // Serial data drive value, always low.
    output wire logic sda_oe, // Serial data pull-down enable.
    input wire logic en_in, // Device enable pin.
    input wire logic addr_select_in, // Slave address select pin.
    input wire logic core_default_sel, // Regulator A default select pin.
    input wire logic [4:0] reg_good_in, // Per-regulator in-regulation flags.
    output wire logic [4:0] reg_enable_out, // Per-regulator enables.
    output wire logic [24:0] reg_code_out, // Five 5-bit output codes.
    output wire logic [4:0] reg_discharge_out, // Active discharge enables.
    output wire logic core_fault_out, // Core reset output.
    output wire logic supply_ok_out // Power-good output.
);
    localparam int PRESC_W = $clog2(MS_CYCLES);

    // Converts a two-bit delay code to milliseconds.
    function automatic logic [7:0] delay_ms(input logic [1:0] code);
        delay_ms = 8'(code * STEP_MS);
    endfunction

    localparam logic [7:0] DLY_DEF = delay_ms(CTRL_RST[CT_RST_DLY +: 2]);

    link_if lk ();

    serial_link u_link (
        .scl_clk(scl_clk),
        .rst_n(resetn),
        .sda_in(sda_in),
        .lk(lk)
    );

    logic [9:0] sy1_ff;
    logic [9:0] sy2_ff;
    logic scl_d_ff;
    logic sda_d_ff;
    logic [2:0] tg_ff;
    logic busy_ff;
    logic hold_ff;
    logic clr_n_ff;
    logic scl_dd_ff;
    logic en_d_ff;
    logic [7:0] rg_ff [NUM_REGS];
    logic [7:0] ctl_ff;
    logic [4:0] onoff_ff;
    logic [4:0] en_out_ff;
    logic [PRESC_W-1:0] presc_ff;
    logic [1:0] act_ff;
    logic [1:0][7:0] cnt_ff;
    logic [1:0][7:0] lim_ff;
    logic fault_ff;
    logic ok_ff;

    // Pin inputs pass two flip-flops before the core-clock logic reads them.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sy1_ff <= 10'h000;
            sy2_ff <= 10'h000;
        end else begin
            sy1_ff <= {sda_in, scl_clk, core_default_sel, addr_select_in,
                       en_in, reg_good_in};
            sy2_ff <= sy1_ff;
        end
    end

    wire [4:0] good_s = sy2_ff[4:0];
    wire en_s = sy2_ff[5];
    wire sel_s = sy2_ff[7];
    wire scl_s = sy2_ff[8];
    wire sda_s = sy2_ff[9];

    // Start and stop need three high clock samples, which no data bit has.
    wire start_det = scl_s & scl_d_ff & scl_dd_ff & sda_d_ff & ~sda_s;
    wire stop_det = scl_s & scl_d_ff & scl_dd_ff & ~sda_d_ff & sda_s;
    wire nxt_busy = en_s & ~stop_det & (busy_ff | start_det);
    wire nxt_hold = start_det | (hold_ff & scl_s);
    wire wr_evt = en_s & (tg_ff[2] ^ tg_ff[1]);

    // Frame tracking holds the link logic in reset outside frames.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_d_ff <= 1'b0;
            scl_dd_ff <= 1'b0;
            en_d_ff <= 1'b0;
            sda_d_ff <= 1'b0;
            tg_ff <= 3'h0;
            busy_ff <= 1'b0;
            hold_ff <= 1'b0;
            clr_n_ff <= 1'b0;
        end else begin
            scl_d_ff <= scl_s;
            scl_dd_ff <= scl_d_ff;
            en_d_ff <= en_s;
            sda_d_ff <= sda_s;
            tg_ff <= {tg_ff[1:0], lk.wr_tgl};
            busy_ff <= nxt_busy;
            hold_ff <= nxt_hold;
            clr_n_ff <= nxt_busy & ~nxt_hold;
        end
    end

    assign lk.clr_n = clr_n_ff;
    assign lk.addr_bit = sy2_ff[6];

    // Read data selection; reserved bits read as zero.
    wire [7:0] rptr = lk.rd_ptr;
    assign lk.rd_data = (rptr < 8'(NUM_REGS)) ? rg_ff[rptr[2:0]] :
        (rptr == OFF_CTRL) ? ctl_ff :
        (rptr == OFF_ONOFF) ? {3'h0, onoff_ff} : 8'h00;

    wire [7:0] def_a = REG_RST | {3'h0, sel_s ? CODE_A_HIGH : CODE_A_LOW};
    wire [7:0] wptr = lk.wr_ptr;
    wire [7:0] wdat = lk.wr_data;

    // Register file: defaults while disabled, serial writes otherwise.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                rg_ff[i] <= REG_RST;
            end
            rg_ff[IDX_A] <= REG_RST | {3'h0, CODE_A_LOW};
            ctl_ff <= CTRL_RST;
            onoff_ff <= ONOFF_RST;
        end else if (!en_s || !en_d_ff) begin
            // clear settings, once more after the strap has settled
            for (int i = 0; i < NUM_REGS; i++) begin
                rg_ff[i] <= REG_RST;
            end
            rg_ff[IDX_A] <= def_a;
            ctl_ff <= CTRL_RST;
            onoff_ff <= ONOFF_RST;
        end else if (wr_evt) begin
            if (wptr < 8'(NUM_REGS)) begin
                rg_ff[wptr[2:0]] <= wdat & REG_MASK;
            end
            if (wptr == OFF_CTRL) begin
                ctl_ff <= wdat;
            end
            if (wptr == OFF_ONOFF) begin
                onoff_ff <= wdat[4:0];
            end
        end
    end

    // Regulator controls; enables drop while the device is disabled.
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            en_out_ff <= 5'h00;
        end else begin
            en_out_ff <= en_s ? onoff_ff : 5'h00;
        end
    end

    for (genvar i = 0; i < NUM_REGS; i++) begin : g_out
        assign reg_code_out[i*RG_CODE_W +: RG_CODE_W] = rg_ff[i][4:0];
        assign reg_discharge_out[i] = rg_ff[i][RG_DISCH];
    end
    assign reg_enable_out = en_out_ff;

    wire ms_tick = (presc_ff == PRESC_W'(MS_CYCLES - 1));
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            presc_ff <= '0;
        end else begin
            presc_ff <= ms_tick ? '0 : presc_ff + PRESC_W'(1);
        end
    end

    wire [1:0] mon = ctl_ff[CT_MON +: 2];
    wire grp_good = (mon == MON_C) ? good_s[IDX_C] :
        (mon == MON_D) ? good_s[IDX_D] :
        (mon == MON_E) ? good_s[IDX_E] :
        &{good_s[IDX_A], good_s[IDX_C], good_s[IDX_D], good_s[IDX_E]};

    // Supervisor 0 guards the core reset, supervisor 1 power-good.
    wire [1:0] sv_bad = {~en_s | ~grp_good, ~en_s | ~good_s[IDX_A]};
    wire [1:0][1:0] sv_code = {ctl_ff[CT_PG_DLY +: 2],
                               ctl_ff[CT_RST_DLY +: 2]};
    logic [1:0][7:0] nxt_cnt;
    logic [1:0][7:0] nxt_lim;
    logic [1:0] nxt_act;

    for (genvar i = 0; i < 2; i++) begin : g_sv
        wire run = act_ff[i] & (cnt_ff[i] < lim_ff[i]);
        assign nxt_lim[i] = sv_bad[i] ? delay_ms(sv_code[i]) : lim_ff[i];
        assign nxt_act[i] = sv_bad[i] | run;
        assign nxt_cnt[i] = sv_bad[i] ? 8'h00 :
            (run & ms_tick) ? cnt_ff[i] + 8'h01 : cnt_ff[i];
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            act_ff <= 2'h3;
            cnt_ff <= '0;
            lim_ff <= {DLY_DEF, DLY_DEF};
        end else begin
            act_ff <= nxt_act;
            cnt_ff <= nxt_cnt;
            lim_ff <= nxt_lim;
        end
    end

    wire b_on = en_s & onoff_ff[IDX_B];
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            fault_ff <= 1'b0;
            ok_ff <= 1'b0;
        end else begin
            fault_ff <= b_on & (ctl_ff[CT_RST_POL] ~^ act_ff[0]);
            ok_ff <= b_on & (ctl_ff[CT_PG_POL] ^ act_ff[1]);
        end
    end

    assign core_fault_out = fault_ff;
    assign supply_ok_out = ok_ff;
    assign sda_oe = lk.sda_oe;
    assign sda_o = lk.sda_o;

    // Checks on the core behaviour.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    sequence s_a_recover;
        (ctl_ff[CT_RST_DLY +: 2] == 2'h0) && sv_bad[0] ##1 !sv_bad[0];
    endsequence

    sequence s_grp_recover;
        (ctl_ff[CT_PG_DLY +: 2] == 2'h0) && sv_bad[1] ##1 !sv_bad[1];
    endsequence

    a_fault_fast: assert property (
        sv_bad[0] && b_on ##1 b_on |=>
            core_fault_out == $past(ctl_ff[CT_RST_POL]))
        else $error("core reset not asserted after regulator A drop");

    a_rst_zero_dly: assert property (
        s_a_recover ##1 !sv_bad[0] |-> !act_ff[0])
        else $error("core reset not released with zero delay");

    a_pg_zero_dly: assert property (
        s_grp_recover ##1 !sv_bad[1] |-> !act_ff[1])
        else $error("power-good not set with zero delay");

    a_fault_pol: assert property (
        b_on && $stable(b_on) |->
            core_fault_out == ($past(ctl_ff[CT_RST_POL]) ~^ $past(act_ff[0])))
        else $error("core reset output has wrong level");

    a_pg_pol: assert property (
        b_on && $stable(b_on) |->
            supply_ok_out == ($past(ctl_ff[CT_PG_POL]) ^ $past(act_ff[1])))
        else $error("power-good output has wrong level");

    a_restart_count: assert property (
        act_ff[0] && sv_bad[0] |=> cnt_ff[0] == 8'h00 && act_ff[0])
        else $error("delay count not restarted on new fault");

    a_shutdown_clear: assert property (
        !en_s |=> ctl_ff == CTRL_RST && onoff_ff == ONOFF_RST
            && reg_enable_out == 5'h00)
        else $error("settings not cleared while disabled");

    a_strap_default: assert property (
        !en_s |=> rg_ff[IDX_A][4:0] ==
            ($past(sel_s) ? CODE_A_HIGH : CODE_A_LOW))
        else $error("regulator A default code wrong");

    a_bus_ignored: assert property (
        !en_s |=> !clr_n_ff ##1 !clr_n_ff)
        else $error("serial link active while disabled");

    a_write_onoff: assert property (
        wr_evt && wptr == OFF_ONOFF |=> onoff_ff == $past(wdat[4:0])
            ##1 reg_enable_out == $past(wdat[4:0], 2))
        else $error("on/off write not applied");

    a_b_off_quiet: assert property (
        !b_on |=> !core_fault_out && !supply_ok_out)
        else $error("supervisor outputs active with regulator B off");

    a_tick_period: assert property (
        ms_tick |=> !ms_tick [*2])
        else $error("millisecond tick repeats too soon");
endmodule

/* hdl/pwr_ctrl_pkg.sv */
// Shared constants for the regulator control core and its serial link.
package pwr_ctrl_pkg;
    // Register byte offsets on the serial port.
    localparam logic [7:0] OFF_REG_A = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h05;
    localparam logic [7:0] OFF_ONOFF = 8'h06;
    localparam int NUM_REGS = 5;
    // Regulator indices within the on/off word and the register array.
    localparam int IDX_A = 0;
    localparam int IDX_B = 1;
    localparam int IDX_C = 2;
    localparam int IDX_D = 3;
    localparam int IDX_E = 4;
    // Field positions.
    localparam int RG_CODE_W = 5;
    localparam int RG_DISCH = 5;
    localparam int CT_RST_DLY = 0;
    localparam int CT_PG_DLY = 2;
    localparam int CT_MON = 4;
    localparam int CT_RST_POL = 6;
    localparam int CT_PG_POL = 7;
    // Encodings of the power-good monitor field.
    localparam logic [1:0] MON_ALL = 2'h0;
    localparam logic [1:0] MON_C = 2'h1;
    localparam logic [1:0] MON_D = 2'h2;
    localparam logic [1:0] MON_E = 2'h3;
    // Reset values and masks.
    localparam logic [7:0] CTRL_RST = 8'h0A;
    localparam logic [7:0] REG_RST = 8'h20;
    localparam logic [7:0] REG_MASK = 8'h3F;
    localparam logic [4:0] ONOFF_RST = 5'h1F;
    localparam logic [4:0] CODE_A_LOW_DEF = 5'h07;
    localparam logic [4:0] CODE_A_HIGH_DEF = 5'h1B;
    // Timing: delay step in ms and reference cycles per ms.
    localparam int STEP_MS = 50;
    localparam int CLK_NS = 10;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES_DEF = MS_NS / CLK_NS;
    // Upper six bits of the slave address.
    localparam logic [5:0] SLAVE_ID = 6'h04;
endpackage

/* hdl/link_if.sv */
// Bundle between the core clock domain and the serial link domain.
`timescale 1ns/1ns
interface link_if;
    logic clr_n;
    logic addr_bit;
    logic [7:0] rd_data;
    logic wr_tgl;
    logic [7:0] wr_ptr;
    logic [7:0] wr_data;
    logic [7:0] rd_ptr;
    logic sda_oe;
    logic sda_o;
    modport core (output clr_n, addr_bit, rd_data,
                  input wr_tgl, wr_ptr, wr_data, rd_ptr, sda_oe, sda_o);
    modport link (input clr_n, addr_bit, rd_data,
                  output wr_tgl, wr_ptr, wr_data, rd_ptr, sda_oe, sda_o);
endinterface

/* hdl/serial_link.sv */
// Serial slave logic clocked by the bus clock.
`timescale 1ns/1ns
module serial_link
    import pwr_ctrl_pkg::*;
(
    input wire logic scl_clk, // Bus clock from the master.
    input wire logic rst_n, // Core reset, keeps the pointer alive.
    input wire logic sda_in, // Data line level.
    link_if.link lk // Bridge to the core domain.
);
    typedef enum logic [2:0] {L_ADDR, L_PTR, L_WDATA, L_RDATA, L_IDLE} lst_t;
    lst_t st_ff;
    lst_t nxt_st;
    logic [3:0] cnt_ff;
    logic [6:0] sh_ff;
    logic ack_ff;
    logic [7:0] rd_sh_ff;
    logic [7:0] ptr_ff;
    logic [7:0] wptr_ff;
    logic [7:0] wdata_ff;
    logic tgl_ff;
    logic oe_ff;
    logic od_ff;
    wire [7:0] byte_in = {sh_ff, sda_in};
    wire last_bit = (cnt_ff == 4'h7);
    wire ack_slot = (cnt_ff == 4'h8);
    wire addr_hit = (byte_in[7:1] == {SLAVE_ID, lk.addr_bit});
    wire wr_take = lk.clr_n & last_bit & (st_ff == L_WDATA);
    wire ptr_take = lk.clr_n & last_bit & (st_ff == L_PTR);
    wire rd_load = lk.clr_n & ack_slot &
        (((st_ff == L_ADDR) & ack_ff & sh_ff[0]) |
         ((st_ff == L_RDATA) & ~sda_in));
    wire bit_out = rd_sh_ff[3'(4'h7 - cnt_ff)];

    // Next state after the acknowledge slot of each byte.
    always_comb begin
        nxt_st = st_ff;
        if (ack_slot) begin
            case (st_ff)
                L_ADDR: nxt_st = ack_ff ? (sh_ff[0] ? L_RDATA : L_PTR) : L_IDLE;
                L_PTR: nxt_st = L_WDATA;
                L_WDATA: nxt_st = L_WDATA;
                L_RDATA: nxt_st = sda_in ? L_IDLE : L_RDATA;
                default: nxt_st = L_IDLE;
            endcase
        end
    end

    // Per-frame shifting; the core holds this in reset outside frames.
    always_ff @(posedge scl_clk or negedge lk.clr_n) begin
        if (!lk.clr_n) begin
            st_ff <= L_ADDR;
            cnt_ff <= 4'h0;
            sh_ff <= 7'h00;
            ack_ff <= 1'b0;
            rd_sh_ff <= 8'h00;
        end else begin
            st_ff <= nxt_st;
            cnt_ff <= ack_slot ? 4'h0 : cnt_ff + 4'h1;
            if (!ack_slot) begin
                sh_ff <= byte_in[6:0];
            end
            ack_ff <= last_bit & (((st_ff == L_ADDR) & addr_hit) |
                (st_ff == L_PTR) | (st_ff == L_WDATA));
            if (rd_load) begin
                rd_sh_ff <= lk.rd_data;
            end
        end
    end

    // Pointer and write hand-off survive repeated starts.
    always_ff @(posedge scl_clk or negedge rst_n) begin
        if (!rst_n) begin
            ptr_ff <= 8'h00;
            wptr_ff <= 8'h00;
            wdata_ff <= 8'h00;
            tgl_ff <= 1'b0;
        end else begin
            if (ptr_take) begin
                ptr_ff <= byte_in;
            end else if (wr_take | rd_load) begin
                ptr_ff <= ptr_ff + 8'h01;
            end
            if (wr_take) begin
                wptr_ff <= ptr_ff;
                wdata_ff <= byte_in;
                tgl_ff <= ~tgl_ff;
            end
        end
    end

    // Data line is changed only while the clock is low.
    always_ff @(negedge scl_clk or negedge lk.clr_n) begin
        if (!lk.clr_n) begin
            oe_ff <= 1'b0;
            od_ff <= 1'b0;
        end else begin
            oe_ff <= (ack_slot & ack_ff) |
                ((st_ff == L_RDATA) & ~cnt_ff[3] & ~bit_out);
            od_ff <= 1'b0;
        end
    end

    assign lk.wr_tgl = tgl_ff;
    assign lk.wr_ptr = wptr_ff;
    assign lk.wr_data = wdata_ff;
    assign lk.rd_ptr = ptr_ff;
    assign lk.sda_oe = oe_ff;
    assign lk.sda_o = od_ff;
endmodule

/* test/bus_master_model.sv */
// Behavioural serial bus master that drives the bus clock and data line.
`timescale 1ns/1ns
module bus_master_model (
    output logic scl_clk, // Bus clock, stands high outside frames.
    output logic sda_low, // High while the master pulls data low.
    input wire logic sda // Resolved data line level.
);
    initial begin
        scl_clk = 1'b1;
        sda_low = 1'b0;
    end

    // One bit of 15 ns: data set in the low phase, sampled on the rise.
    task automatic bit_io(input logic b, output logic r);
        #3 sda_low = ~b;
        #4 scl_clk = 1'b1;
        r = sda;
        #8 scl_clk = 1'b0;
    endtask

    // Start or repeated start, with long holds so the core sees it; the
    // clock then stays low until the core has released the link logic.
    task automatic start_cond();
        #3 sda_low = 1'b0;
        #4 scl_clk = 1'b1;
        #60 sda_low = 1'b1;
        #60 scl_clk = 1'b0;
        #60;
    endtask

    // Stop: data rises while the clock stands high, then the bus idles.
    task automatic stop_cond();
        #3 sda_low = 1'b1;
        #4 scl_clk = 1'b1;
        #60 sda_low = 1'b0;
        #60;
    endtask

    // Eight bits MSB first, then the acknowledge bit; last high releases.
    task automatic byte_io(input logic [7:0] d, input logic last,
                           output logic [7:0] q, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], q[i]);
        end
        bit_io(last, r);
        ack = ~r;
    endtask

    // Single-byte register write; ok is high when every byte was taken.
    task automatic write_reg(input logic [6:0] dev, input logic [7:0] p,
                             input logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, a0);
        byte_io(p, 1'b1, q, a1);
        byte_io(d, 1'b1, q, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // Single-byte register read ended by a master refusal.
    task automatic read_reg(input logic [6:0] dev, input logic [7:0] p,
                            output logic [7:0] d, output logic ok);
        logic [7:0] q;
        logic a0, a1, a2, a3;
        start_cond();
        byte_io({dev, 1'b0}, 1'b1, q, a0);
        byte_io(p, 1'b1, q, a1);
        start_cond();
        byte_io({dev, 1'b1}, 1'b1, q, a2);
        byte_io(8'hFF, 1'b1, d, a3);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule

/* test/regulator_reset_pgood_control_tb.sv */
// Self-checking bench for the regulator control core.
`timescale 1ns/1ns
module regulator_reset_pgood_control_tb;
    import pwr_ctrl_pkg::*;
    localparam int MS = 10;
    logic clk_sys = 1'b0;
    logic resetn, en_in, addr_select_in, core_default_sel, ok, pol;
    logic [4:0] reg_good_in;
    wire logic scl_clk, sda_low, sda_o, sda_oe, core_fault_out, supply_ok_out;
    wire logic [4:0] reg_enable_out, reg_discharge_out;
    wire logic [24:0] reg_code_out;
    int fail_count = 0;
    int n_checks = 0;
    int exp_reg[7];
    int idx;
    // Open-drain data line with a pull-up.
    wire logic sda = ~(sda_low | (sda_oe & ~sda_o));

    always #5 clk_sys = ~clk_sys;

    bus_master_model m (.scl_clk(scl_clk), .sda_low(sda_low), .sda(sda));

    pwr_ctrl_core #(.MS_CYCLES(MS)) dut (
        .clk_sys(clk_sys), .resetn(resetn), .scl_clk(scl_clk),
        .sda_in(sda), .sda_o(sda_o), .sda_oe(sda_oe), .en_in(en_in),
        .addr_select_in(addr_select_in),
        .core_default_sel(core_default_sel), .reg_good_in(reg_good_in),
        .reg_enable_out(reg_enable_out), .reg_code_out(reg_code_out),
        .reg_discharge_out(reg_discharge_out),
        .core_fault_out(core_fault_out), .supply_ok_out(supply_ok_out)
    );

    task automatic check(input string what, input logic [31:0] e,
                         input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %0h seen %0h", what, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge clk_sys);
    endtask

    // Register model loaded with the start-up values.
    function automatic void model_defaults();
        for (int i = 0; i < NUM_REGS; i++) begin
            exp_reg[i] = 32'(REG_RST);
        end
        exp_reg[IDX_A] = 32'(REG_RST) | (core_default_sel ?
            32'(CODE_A_HIGH_DEF) : 32'(CODE_A_LOW_DEF));
        exp_reg[5] = 32'(CTRL_RST);
        exp_reg[6] = 32'(ONOFF_RST);
    endfunction

    // Write one register and keep the model in step.
    task automatic wr(input logic [7:0] p, input logic [7:0] d);
        m.write_reg({SLAVE_ID, addr_select_in}, p, d, ok);
        check("write ack", 1, ok);
        if (p < OFF_CTRL) exp_reg[p] = 32'(d & REG_MASK);
        else if (p == OFF_CTRL) exp_reg[5] = 32'(d);
        else if (p == OFF_ONOFF) exp_reg[6] = 32'(d & 8'h1F);
    endtask

    // Read one register; unmapped places read zero.
    task automatic rd(input logic [7:0] p);
        logic [7:0] q;
        m.read_reg({SLAVE_ID, addr_select_in}, p, q, ok);
        check("read ack", 1, ok);
        check($sformatf("reg %0h", p), (p < 7) ? exp_reg[p] : 0, q);
    endtask

    // Regulator outputs against the model.
    task automatic check_outs();
        logic [24:0] ec;
        logic [4:0] ed;
        for (int i = 0; i < NUM_REGS; i++) begin
            ec[5*i +: 5] = exp_reg[i][4:0];
            ed[i] = exp_reg[i][RG_DISCH];
        end
        check("codes", ec, reg_code_out);
        check("discharge", ed, reg_discharge_out);
        check("enables", exp_reg[6][4:0], reg_enable_out);
    endtask

    // Cycles until a supervisor output reaches a level, within lo..hi.
    task automatic wait_lvl(input logic pg, input logic lvl, input int lo,
                            input int hi);
        int n;
        n = 0;
        while ((pg ? supply_ok_out : core_fault_out) !== lvl && n <= hi) begin
            @(negedge clk_sys);
            n++;
        end
        check(pg ? "pgood time" : "reset time", 1, n >= lo && n <= hi);
        if (n > hi) results();
    endtask

    initial begin
        void'($urandom(95870));
        resetn <= 1'b0;
        en_in <= 1'b1;
        addr_select_in <= 1'($urandom);
        core_default_sel <= 1'($urandom);
        reg_good_in <= 5'h1F;
        cyc(6);
        resetn <= 1'b1;
        model_defaults();
        wait_lvl(0, 1'b1, 90 * MS, 110 * MS);
        wait_lvl(1, 1'b0, 0, 110 * MS);
        for (int p = 0; p < 8; p++) rd(8'(p));
        check_outs();
        for (int p = 0; p < 8; p++) wr(8'(p), 8'($urandom));
        for (int p = 0; p < 8; p++) rd(8'(p));
        check_outs();
        // The other slave address is neither answered nor stored.
        m.write_reg({SLAVE_ID, ~addr_select_in}, OFF_REG_A, 8'h15, ok);
        check("foreign ack", 0, ok);
        rd(OFF_REG_A);
        wr(OFF_ONOFF, 8'h1F);
        // Every reset delay code, with a relapse in mid-delay for codes 1 to 3.
        for (int c = 0; c < 4; c++) begin
            pol = 1'($urandom);
            wr(OFF_CTRL, {1'b0, pol, 4'h0, 2'(c)});
            cyc(1);
            reg_good_in[IDX_A] <= 1'b0;
            wait_lvl(0, pol, 0, 5);
            cyc(20);
            reg_good_in[IDX_A] <= 1'b1;
            cyc(300);
            reg_good_in[IDX_A] <= 1'b0;
            cyc(5);
            reg_good_in[IDX_A] <= 1'b1;
            wait_lvl(0, ~pol, c * 50 * MS - 2 * MS, c * 50 * MS + 20);
        end
        // Every monitor group and power-good delay code.
        for (int g = 0; g < 4; g++) begin
            pol = 1'($urandom);
            wr(OFF_CTRL, {pol, 1'b0, 2'(g), 2'(g), 2'b00});
            idx = (g == 0) ? IDX_B : IDX_A;
            cyc(1);
            reg_good_in[idx] <= 1'b0;
            cyc(20);
            @(negedge clk_sys);
            check("pgood ignores", pol, supply_ok_out);
            cyc(1);
            reg_good_in <= 5'h1F;
            idx = (g == 0) ? IDX_A : g + 1;
            cyc(20);
            reg_good_in[idx] <= 1'b0;
            wait_lvl(1, ~pol, 0, 5);
            cyc(1);
            reg_good_in[idx] <= 1'b1;
            wait_lvl(1, pol, g * 50 * MS - 2 * MS, g * 50 * MS + 20);
        end
        // Regulator B off silences both supervisor outputs.
        wr(OFF_CTRL, 8'h80);
        wait_lvl(1, 1'b1, 0, 20);
        wr(OFF_ONOFF, 8'h1D);
        cyc(5);
        @(negedge clk_sys);
        check("reset out b off", 0, core_fault_out);
        check("pgood out b off", 0, supply_ok_out);
        check_outs();
        wr(OFF_ONOFF, 8'h1F);
        wait_lvl(0, 1'b1, 0, 1600);
        // Shutdown drops everything and ignores the bus.
        cyc(1);
        en_in <= 1'b0;
        core_default_sel <= ~core_default_sel;
        cyc(10);
        @(negedge clk_sys);
        check("enables off", 0, reg_enable_out);
        check("reset out off", 0, core_fault_out);
        m.write_reg({SLAVE_ID, addr_select_in}, OFF_REG_A, 8'h01, ok);
        check("ack while off", 0, ok);
        cyc(1);
        en_in <= 1'b1;
        cyc(10);
        model_defaults();
        for (int p = 0; p < 7; p++) rd(8'(p));
        results();
    end
endmodule
